// >>> logic/gii_top.sv
// Instrument-side GPIB function logic: handshakes, talker, listener,
// service request, remote/local, clear, trigger and indicators.
// Assumes bus inputs are synchronous, active high (true = asserted),
// and external open-collector drivers turn oe into a low line.
`timescale 1ns/1ps
module gii_top
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [7:0]  dip_sw,
    input  wire logic [7:0]  dio_i,
    output logic [7:0]       dio_o,
    output logic             dio_oe,
    input  wire logic        dav_i,
    output logic             dav_oe,
    input  wire logic        nrfd_i,
    output logic             nrfd_oe,
    input  wire logic        ndac_i,
    output logic             ndac_oe,
    input  wire logic        eoi_i,
    output logic             eoi_oe,
    output logic             srq_oe,
    input  wire logic        atn_i,
    input  wire logic        ifc_i,
    input  wire logic        ren_i,
    input  wire logic [7:0]  rd_data,
    input  wire logic        rd_last,
    input  wire logic        rd_valid,
    output logic             rd_ready,
    input  wire logic        button_i,
    input  wire logic        reading_done,
    input  wire logic        svc_req,
    output logic             meas_start,
    output logic             dev_clear,
    output logic [7:0]       rx_data,
    output logic             rx_valid,
    output logic             buttons_en,
    output logic             ind_remote,
    output logic             ind_listen,
    output logic             ind_talk,
    output logic             ind_lockout
);
    import gii_pkg::*;

    gii_ah_t     ah_r, ah_nxt;
    gii_sh_t     sh_r, sh_nxt;
    logic        ton_r, ton_nxt, cfg_r, cfg_nxt;
    logic [4:0]  addr_r, addr_nxt;
    logic        lad_r, lad_nxt, tad_r, tad_nxt, spm_r, spm_nxt;
    logic        rem_r, rem_nxt, llo_r, llo_nxt;
    logic        rqs_r, rqs_nxt, mav_r, mav_nxt;
    logic        stb_sent_r, stb_sent_nxt;
    logic [7:0]  rxd_r, rxd_nxt, txd_r, txd_nxt;
    logic        rxv_r, rxv_nxt, eoi_r, eoi_nxt;
    logic        meas_r, meas_nxt, clr_r, clr_nxt;
    logic        tgo_r, tgo_nxt, ah_off;
    logic [$clog2(SETTLE_CYC+1)-1:0] st_r, st_nxt;
    logic [$clog2(BLINK_CYC+1)-1:0]  bl_r, bl_nxt;
    logic        btn_r, btn_nxt;
    logic [7:0]  byte_in, cmd7;
    logic        got, f_ready, f_valid, f_last, f_pop, f_flush;
    logic [7:0]  f_data;
    logic [8:0]  f_word;

    // address: off switch adds its weight (4..8 = 16..1)
    logic [4:0] sw_addr;
    assign sw_addr = ~{dip_sw[3], dip_sw[4], dip_sw[5], dip_sw[6], dip_sw[7]};
    assign byte_in = dio_i;
    assign cmd7    = byte_in & CMD_MASK7;
    // byte taken when DAV seen while ready
    assign got     = (ah_r == GII_AH_RDY) && dav_i;
    assign ah_off  = (ah_nxt == GII_AH_IDLE) && tgo_nxt;

    // Readings queue; back-pressure reaches the measurement source
    gii_fifo #(.W(FIFO_W + 1), .D(FIFO_D)) u_fifo
    (
        .clk       (clk),
        .rst_n     (rst_n),
        .en        (ce),
        .flush     (f_flush),
        .in_data   ({rd_last, rd_data}),
        .in_valid  (rd_valid),
        .in_ready  (rd_ready),
        .out_data  (f_word),
        .out_valid (f_valid),
        .out_ready (f_pop)
    );
    assign f_ready = 1'b1;
    assign f_data  = f_word[7:0];
    assign f_last  = f_word[8];
    assign f_flush = clr_r || ifc_i;

    // Acceptor handshake
    always_comb
    begin
        ah_nxt = ah_r;
        // commands always accepted, data only when listening
        // data only while addressed to listen
        case (ah_r)
            GII_AH_IDLE: if (atn_i || lad_r) ah_nxt = GII_AH_RDY;
            GII_AH_RDY:
            begin
                if (dav_i) ah_nxt = GII_AH_ACPT;
                else if (!atn_i && !lad_r) ah_nxt = GII_AH_IDLE;
            end
            GII_AH_ACPT: ah_nxt = GII_AH_WAIT;
            // hold NDAC released until DAV drops
            GII_AH_WAIT: if (!dav_i) ah_nxt = GII_AH_IDLE;
            default: ah_nxt = GII_AH_IDLE;
        endcase
        if (ifc_i) ah_nxt = GII_AH_IDLE;
    end

    // Interface function state
    always_comb
    begin
        ton_nxt = ton_r;
        cfg_nxt = cfg_r;
        addr_nxt = addr_r;
        lad_nxt = lad_r;
        tad_nxt = tad_r;
        spm_nxt = spm_r;
        rem_nxt = rem_r;
        llo_nxt = llo_r;
        rqs_nxt = rqs_r;
        mav_nxt = mav_r;
        rxd_nxt = rxd_r;
        rxv_nxt = 1'b0;
        meas_nxt = 1'b0;
        clr_nxt = 1'b0;
        btn_nxt = button_i;
        bl_nxt = (bl_r != '0) ? bl_r - 1'b1 : bl_r;
        // switch sampled once after reset release
        if (!cfg_r)
        begin
            cfg_nxt = 1'b1;
            ton_nxt = !dip_sw[0];
            addr_nxt = sw_addr;
        end
        if (got && atn_i)
        begin
            if (byte_in[6:5] == GRP_LAG[6:5] && !ton_r)
            begin
                if (cmd7 == CMD_UNL) lad_nxt = 1'b0;
                else if (byte_in[4:0] == addr_r)
                begin
                    lad_nxt = 1'b1;
                    tad_nxt = 1'b0;
                    // remote when addressed with REN true
                    if (ren_i) rem_nxt = 1'b1;
                end
            end
            else if (byte_in[6:5] == GRP_TAG[6:5] && !ton_r)
            begin
                if (cmd7 == CMD_UNT) tad_nxt = 1'b0;
                else if (byte_in[4:0] == addr_r)
                begin
                    tad_nxt = 1'b1;
                    lad_nxt = 1'b0;
                    // reading requested, not a poll: clear done
                    if (!spm_r) mav_nxt = 1'b0;
                end
                else tad_nxt = 1'b0;
            end
            else if (byte_in[6:5] == 2'b00)
            begin
                // parallel poll commands fall through, unanswered
                case (cmd7)
                    CMD_LLO: if (ren_i) llo_nxt = 1'b1;
                    CMD_SPE: spm_nxt = 1'b1;
                    CMD_SPD: spm_nxt = 1'b0;
                    CMD_DCL: clr_nxt = 1'b1;
                    CMD_SDC: if (lad_r) clr_nxt = 1'b1;
                    CMD_GTL: if (lad_r) rem_nxt = 1'b0;
                    CMD_GET: if (lad_r) meas_nxt = 1'b1;
                    default: ;
                endcase
            end
        end
        if (got && !atn_i && lad_r)
        begin
            rxd_nxt = byte_in;
            rxv_nxt = 1'b1;
        end
        // button triggers a reading in talk-only
        if (ton_r && button_i && !btn_r) meas_nxt = 1'b1;
        // bit 3 on reading done, set beats clear
        if (reading_done)
        begin
            mav_nxt = 1'b1;
            if (ton_r) bl_nxt = BLINK_CYC[$bits(bl_r)-1:0];
        end
        // bit 6 cleared by serial poll, set wins
        if (stb_sent_r) rqs_nxt = 1'b0;
        if (svc_req) rqs_nxt = 1'b1;
        // lockout released only when REN drops or IFC is true
        if (!ren_i)
        begin
            rem_nxt = 1'b0;
            llo_nxt = 1'b0;
        end
        if (ifc_i)
        begin
            lad_nxt = 1'b0;
            tad_nxt = 1'b0;
            spm_nxt = 1'b0;
            rem_nxt = 1'b0;
            llo_nxt = 1'b0;
        end
    end

    // Source handshake and talker
    always_comb
    begin
        sh_nxt = sh_r;
        st_nxt = st_r;
        txd_nxt = txd_r;
        eoi_nxt = eoi_r;
        stb_sent_nxt = 1'b0;
        f_pop = 1'b0;
        // talk when addressed, or talk-only with a reading
        tgo_nxt = !atn_i && (ton_r || tad_r);
        case (sh_r)
            GII_SH_IDLE:
            begin
                if (tgo_r && spm_r && !ton_r)
                begin
                    txd_nxt = 8'h00;
                    txd_nxt[STB_RQS] = rqs_r;
                    txd_nxt[STB_MAV] = mav_r;
                    eoi_nxt = 1'b0;
                    sh_nxt = GII_SH_SET;
                    st_nxt = SETTLE_CYC[$bits(st_r)-1:0];
                    stb_sent_nxt = 1'b1;
                end
                else if (tgo_r && f_valid && f_ready)
                begin
                    txd_nxt = f_data;
                    eoi_nxt = f_last;
                    f_pop = 1'b1;
                    sh_nxt = GII_SH_SET;
                    st_nxt = SETTLE_CYC[$bits(st_r)-1:0];
                end
            end
            // data settles, then wait for all ready
            GII_SH_SET:
            begin
                if (st_r != '0) st_nxt = st_r - 1'b1;
                else if (!nrfd_i) sh_nxt = GII_SH_DAV;
            end
            GII_SH_DAV: if (!ndac_i) sh_nxt = GII_SH_REL;
            GII_SH_REL: sh_nxt = GII_SH_IDLE;
            default: sh_nxt = GII_SH_IDLE;
        endcase
        if (atn_i || ifc_i) sh_nxt = GII_SH_IDLE;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ah_r <= GII_AH_IDLE;
            sh_r <= GII_SH_IDLE;
            ton_r <= 1'b0;
            cfg_r <= 1'b0;
            addr_r <= ADDR_DFLT;
            lad_r <= 1'b0;
            tad_r <= 1'b0;
            spm_r <= 1'b0;
            rem_r <= 1'b0;
            llo_r <= 1'b0;
            rqs_r <= 1'b0;
            mav_r <= 1'b0;
            stb_sent_r <= 1'b0;
            rxd_r <= 8'h00;
            txd_r <= 8'h00;
            rxv_r <= 1'b0;
            eoi_r <= 1'b0;
            meas_r <= 1'b0;
            clr_r <= 1'b0;
            tgo_r <= 1'b0;
            st_r <= '0;
            bl_r <= '0;
            btn_r <= 1'b0;
        end
        else if (ce)
        begin
            ah_r <= ah_nxt;
            sh_r <= sh_nxt;
            ton_r <= ton_nxt;
            cfg_r <= cfg_nxt;
            addr_r <= addr_nxt;
            lad_r <= lad_nxt;
            tad_r <= tad_nxt;
            spm_r <= spm_nxt;
            rem_r <= rem_nxt;
            llo_r <= llo_nxt;
            rqs_r <= rqs_nxt;
            mav_r <= mav_nxt;
            stb_sent_r <= stb_sent_nxt;
            rxd_r <= rxd_nxt;
            txd_r <= txd_nxt;
            rxv_r <= rxv_nxt;
            eoi_r <= eoi_nxt;
            meas_r <= meas_nxt;
            clr_r <= clr_nxt;
            tgo_r <= tgo_nxt;
            st_r <= st_nxt;
            bl_r <= bl_nxt;
            btn_r <= btn_nxt;
        end
    end

    // Output registers; oe high means the line is pulled true
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dio_o <= 8'h00;
            dio_oe <= 1'b0;
            dav_oe <= 1'b0;
            nrfd_oe <= 1'b0;
            ndac_oe <= 1'b0;
            eoi_oe <= 1'b0;
            srq_oe <= 1'b0;
            meas_start <= 1'b0;
            dev_clear <= 1'b0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            buttons_en <= 1'b1;
            ind_remote <= 1'b0;
            ind_listen <= 1'b0;
            ind_talk <= 1'b0;
            ind_lockout <= 1'b0;
        end
        else if (ce)
        begin
            // data driven only by the source handshake
            dio_o <= txd_nxt;
            dio_oe <= sh_nxt != GII_SH_IDLE;
            // DAV true only in the valid state
            dav_oe <= sh_nxt == GII_SH_DAV;
            eoi_oe <= (sh_nxt != GII_SH_IDLE) && eoi_nxt;
            // NRFD held unless ready, NDAC until accepted
            // idle acceptor lets go while talking, else own NRFD stalls
            nrfd_oe <= (ah_nxt != GII_AH_RDY) && !ah_off;
            ndac_oe <= (ah_nxt != GII_AH_WAIT) && (ah_nxt != GII_AH_ACPT)
                       && !ah_off;
            // SRQ line follows the pending request
            srq_oe <= rqs_nxt;
            meas_start <= meas_nxt;
            // clear pulse to the configuration store
            dev_clear <= clr_nxt;
            rx_data <= rxd_nxt;
            rx_valid <= rxv_nxt;
            buttons_en <= !llo_nxt;
            ind_remote <= rem_nxt;
            ind_listen <= lad_nxt || (bl_nxt != '0);
            ind_talk <= ton_nxt || tad_nxt;
            ind_lockout <= llo_nxt;
        end
    end
    // no ATN or IFC driver exists in this block
endmodule

// >>> logic/gii_pkg.sv
// Constants and types for the instrument-side GPIB function logic.
// Assumes a single 10 MHz clock and bus lines already synchronised.
package gii_pkg;
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned FIFO_W      = 8;
    localparam int unsigned FIFO_D      = 32;
    // Bus settle time before DAV, ns, rounded up to cycles
    localparam int unsigned SETTLE_NS   = 2000;
    localparam int unsigned SETTLE_CYC  =
        (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Listen indicator pulse in talk-only mode, ms
    localparam int unsigned BLINK_MS    = 100;
    localparam int unsigned BLINK_CYC   = BLINK_MS * (CLK_HZ / 1000);
    localparam logic [4:0]  ADDR_DFLT   = 5'h06;
    localparam logic [4:0]  ADDR_CTRL   = 5'h00;
    // Status byte bit positions
    localparam int unsigned STB_RQS     = 6;
    localparam int unsigned STB_MAV     = 3;
    // Command byte groups, masked with GRP_MASK
    localparam logic [7:0]  GRP_MASK    = 8'h60;
    localparam logic [7:0]  GRP_LAG     = 8'h20;
    localparam logic [7:0]  GRP_TAG     = 8'h40;
    localparam logic [7:0]  GRP_SCG     = 8'h60;
    localparam logic [7:0]  ADR_MASK    = 8'h1F;
    localparam logic [7:0]  CMD_UNL     = 8'h3F;
    localparam logic [7:0]  CMD_UNT     = 8'h5F;
    localparam logic [7:0]  CMD_GTL     = 8'h01;
    localparam logic [7:0]  CMD_SDC     = 8'h04;
    localparam logic [7:0]  CMD_GET     = 8'h08;
    localparam logic [7:0]  CMD_LLO     = 8'h11;
    localparam logic [7:0]  CMD_DCL     = 8'h14;
    localparam logic [7:0]  CMD_SPE     = 8'h18;
    localparam logic [7:0]  CMD_SPD     = 8'h19;
    localparam logic [7:0]  CMD_MASK7   = 8'h7F;

    typedef enum logic [1:0]
    {
        GII_AH_IDLE = 2'b00,
        GII_AH_RDY  = 2'b01,
        GII_AH_ACPT = 2'b11,
        GII_AH_WAIT = 2'b10
    } gii_ah_t;

    typedef enum logic [1:0]
    {
        GII_SH_IDLE = 2'b00,
        GII_SH_SET  = 2'b01,
        GII_SH_DAV  = 2'b11,
        GII_SH_REL  = 2'b10
    } gii_sh_t;
endpackage

// >>> logic/gii_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; en freezes all state.
`timescale 1ns/1ps
module gii_fifo
#(
    parameter int unsigned W = 8,
    parameter int unsigned D = 32
)
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         en,
    input  wire logic         flush,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int unsigned AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wp_r, wp_nxt, rp_r, rp_nxt;
    logic         push, pop;

    assign in_ready  = (wp_r - rp_r) != (AW+1)'(D);
    assign out_valid = wp_r != rp_r;
    assign out_data  = mem[rp_r[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        wp_nxt = flush ? '0 : wp_r + (AW+1)'(push);
        rp_nxt = flush ? '0 : rp_r + (AW+1)'(pop);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else if (en)
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            if (push && !flush)
                mem[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule

// >>> sim/gii_top_chk.sv
// Port-level checker for the instrument GPIB function block.
// Bound into gii_top; sees only its ports.
`timescale 1ns/1ps
module gii_top_chk
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] dio_o,
    input wire logic       dio_oe,
    input wire logic       dav_i,
    input wire logic       dav_oe,
    input wire logic       nrfd_i,
    input wire logic       nrfd_oe,
    input wire logic       ndac_i,
    input wire logic       ndac_oe,
    input wire logic       eoi_oe,
    input wire logic       srq_oe,
    input wire logic       atn_i,
    input wire logic       ifc_i,
    input wire logic       ren_i,
    input wire logic       svc_req,
    input wire logic       buttons_en,
    input wire logic       ind_remote,
    input wire logic       ind_lockout
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    src_settle_a: assert property (
        $rose(dav_oe) |-> !$past(nrfd_i) && $past(dio_oe, 18) && dio_oe)
        else $error("dav raised before settle or ready");
    src_hold_a: assert property (
        dav_oe |-> dio_oe && $stable(dio_o))
        else $error("data moved under dav");
    src_release_a: assert property (
        dav_oe && !ndac_i |-> ##[1:2] !dav_oe)
        else $error("dav held after accept");
    eoi_pair_a: assert property (
        $rose(eoi_oe) |-> dio_oe)
        else $error("eoi without data");
    acc_take_a: assert property (
        dav_i && !dav_oe && !nrfd_oe && ndac_oe && !ifc_i
        |=> nrfd_oe && !ndac_oe)
        else $error("acceptor missed dav");
    acc_hold_a: assert property (
        nrfd_oe && !ndac_oe && dav_i && !dav_oe && !ifc_i |=> nrfd_oe)
        else $error("ready before dav dropped");
    atn_quiet_a: assert property (
        atn_i [*3] |-> !dio_oe && !dav_oe)
        else $error("data driven under atn");
    srq_raise_a: assert property (
        $rose(svc_req) |-> ##[1:3] srq_oe)
        else $error("srq not raised");
    lock_buttons_a: assert property (
        ind_lockout |-> !buttons_en)
        else $error("buttons live in lockout");
    ren_local_a: assert property (
        !ren_i [*3] |-> !ind_remote && !ind_lockout)
        else $error("remote kept without ren");
endmodule

bind gii_top gii_top_chk u_chk (.clk, .rst_n, .dio_o, .dio_oe, .dav_i,
    .dav_oe, .nrfd_i, .nrfd_oe, .ndac_i, .ndac_oe, .eoi_oe, .srq_oe,
    .atn_i, .ifc_i, .ren_i, .svc_req, .buttons_en, .ind_remote,
    .ind_lockout);

// >>> sim/gii_ctl_model.sv
// Bus controller model: sources commands and data, accepts talker bytes.
// Lines are true-high; released lines read 0 through the pull-ups.
`timescale 1ns/1ps
module gii_ctl_model
(
    input wire logic       clk,
    input wire logic [7:0] dio_w,
    input wire logic       dav_w,
    input wire logic       nrfd_w,
    input wire logic       ndac_w,
    input wire logic       eoi_w,
    output logic [7:0]     ctl_dio,
    output logic           ctl_dav,
    output logic           ctl_nrfd,
    output logic           ctl_ndac,
    output logic           ctl_eoi,
    output logic           atn,
    output logic           ifc,
    output logic           ren
);
    initial
    begin
        {ctl_dio, ctl_dav, ctl_eoi, atn, ifc, ren} = '0;
        {ctl_nrfd, ctl_ndac} = 2'b11;
    end

    task automatic send(input logic [7:0] b, input logic a,
                        output logic ok);
        int n;
        begin
            n = 0;
            atn = a;
            {ctl_nrfd, ctl_ndac} = 2'b00;
            while (nrfd_w !== 1'b0 && n < 40)
            begin
                @(posedge clk);
                #10 n++;
            end
            ok = (nrfd_w === 1'b0);
            if (ok)
            begin
                ctl_dio = b;
                repeat (2) @(posedge clk);
                #10 ctl_dav = 1'b1;
                n = 0;
                while (ndac_w !== 1'b0 && n < 40)
                begin
                    @(posedge clk);
                    #10 n++;
                end
                ok = (ndac_w === 1'b0);
            end
            ctl_dav = 1'b0;
            ctl_dio = 8'h00;
            {ctl_nrfd, ctl_ndac} = 2'b11;
            repeat (3) @(posedge clk);
            #10;
        end
    endtask

    // acceptor handshake, stall delays NDAC release after DAV
    task automatic recv(input int stall, output logic [7:0] b,
                        output logic e, output logic ok);
        int n;
        begin
            n = 0;
            atn = 1'b0;
            ctl_nrfd = 1'b0;
            while (dav_w !== 1'b1 && n < 300)
            begin
                @(posedge clk);
                #10 n++;
            end
            ok = (dav_w === 1'b1);
            b = dio_w;
            e = eoi_w;
            ctl_nrfd = 1'b1;
            repeat (stall + 1) @(posedge clk);
            #10 ctl_ndac = 1'b0;
            n = 0;
            while (dav_w !== 1'b0 && n < 20)
            begin
                @(posedge clk);
                #10 n++;
            end
            ctl_ndac = 1'b1;
        end
    endtask
endmodule

// >>> sim/gpib_instrument_interface_test.sv
// Self-checking bench for gii_top against the controller model.
// Open-collector lines are the OR of every party's drive.
`timescale 1ns/1ps
module gpib_instrument_interface_test;
    import gii_pkg::*;
    localparam logic [7:0] ADR = 8'h0B;
    localparam logic [7:0] DIP = 8'h2F;
    logic clk, rst_n, button_i, reading_done, svc_req;
    logic rd_last, rd_valid, rd_ready, meas_start, dev_clear, rx_valid;
    logic dio_oe, dav_oe, nrfd_oe, ndac_oe, eoi_oe, srq_oe, buttons_en;
    logic ind_remote, ind_listen, ind_talk, ind_lockout;
    logic ctl_dav, ctl_nrfd, ctl_ndac, ctl_eoi, atn, ifc, ren, ok, e;
    logic [7:0] dip_sw, dio_o, rd_data, rx_data, ctl_dio, b, rx_last;
    wire  [7:0] dio_w = ctl_dio | (dio_oe ? dio_o : 8'h00);
    wire        dav_w = ctl_dav | dav_oe;
    wire        nrfd_w = ctl_nrfd | nrfd_oe;
    wire        ndac_w = ctl_ndac | ndac_oe;
    wire        eoi_w = ctl_eoi | eoi_oe;
    int err_count, check_count, cyc, rx_cnt, meas_cnt, clr_cnt, n;

    gii_top u_dut (.clk, .rst_n, .ce(1'b1), .dip_sw, .dio_i(dio_w), .dio_o,
        .dio_oe, .dav_i(dav_w), .dav_oe, .nrfd_i(nrfd_w), .nrfd_oe,
        .ndac_i(ndac_w), .ndac_oe, .eoi_i(eoi_w), .eoi_oe, .srq_oe,
        .atn_i(atn), .ifc_i(ifc), .ren_i(ren), .rd_data, .rd_last,
        .rd_valid, .rd_ready, .button_i, .reading_done, .svc_req,
        .meas_start, .dev_clear, .rx_data, .rx_valid, .buttons_en,
        .ind_remote, .ind_listen, .ind_talk, .ind_lockout);
    gii_ctl_model u_ctl (.clk, .dio_w, .dav_w, .nrfd_w, .ndac_w, .eoi_w,
        .ctl_dio, .ctl_dav, .ctl_nrfd, .ctl_ndac, .ctl_eoi, .atn, .ifc,
        .ren);

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (rx_valid === 1'b1)
        begin
            rx_cnt <= rx_cnt + 1;
            rx_last <= rx_data;
        end
        if (meas_start === 1'b1)
            meas_cnt <= meas_cnt + 1;
        if (dev_clear === 1'b1)
            clr_cnt <= clr_cnt + 1;
        if (cyc == 20000)
        begin
            err_count++;
            stop_test;
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #10;
    endtask

    task automatic cmd(input logic [7:0] c);
        u_ctl.send(c, 1'b1, ok);
        chk("cmd ack", 8'(ok), 8'h01);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(3);
    endtask

    task automatic powerup(input logic [7:0] sw);
        rst_n = 1'b0;
        dip_sw = sw;
        tick(20);
        rst_n = 1'b1;
        tick(3);
    endtask

    task automatic t_reset;
        chk("idle ind", {4'h0, ind_remote, ind_listen, ind_talk,
            ind_lockout}, 8'h00);
        chk("idle drv", {dio_oe, dav_oe, srq_oe, buttons_en}, 8'h01);
    endtask

    task automatic t_listen;
        u_ctl.send(8'h33, 1'b0, ok);
        chk("refused", {ok, 7'(rx_cnt)}, 8'h00);
        u_ctl.ren = 1'b1;
        cmd(GRP_LAG | (ADR ^ 8'h01));
        chk("other adr", 8'(ind_listen), 8'h00);
        cmd(GRP_LAG | ADR);
        chk("listen", {ind_listen, ind_remote}, 8'h03);
        u_ctl.send(8'hA5, 1'b0, ok);
        tick(2);
        chk("rx byte", rx_last, 8'hA5);
        chk("rx count", 8'(rx_cnt), 8'h01);
        cmd(CMD_LLO);
        chk("lockout", {ind_lockout, buttons_en}, 8'h02);
        cmd(CMD_GTL);
        chk("gtl", {ind_remote, ind_lockout}, 8'h01);
        cmd(CMD_SDC);
        cmd(CMD_GET);
        cmd(CMD_DCL);
        chk("clears", 8'(clr_cnt), 8'h02);
        chk("trigger", 8'(meas_cnt), 8'h01);
        u_ctl.ren = 1'b0;
        tick(4);
        chk("ren off", {ind_lockout, buttons_en}, 8'h01);
        u_ctl.ifc = 1'b1;
        tick(3);
        u_ctl.ifc = 1'b0;
        tick(2);
        chk("ifc idle", 8'(ind_listen), 8'h00);
    endtask

    task automatic t_poll;
        pulse(svc_req);
        pulse(reading_done);
        chk("srq", 8'(srq_oe), 8'h01);
        {u_ctl.atn, u_ctl.ctl_eoi} = 2'b11;
        tick(5);
        chk("par poll", 8'(dio_oe), 8'h00);
        {u_ctl.atn, u_ctl.ctl_eoi} = 2'b00;
        cmd(CMD_SPE);
        cmd(GRP_TAG | ADR);
        u_ctl.recv(0, b, e, ok);
        chk("stb", b, 8'h48);
        cmd(CMD_SPD);
        cmd(CMD_UNT);
        chk("srq clr", 8'(srq_oe), 8'h00);
    endtask

    task automatic t_fifo;
        n = 0;
        rd_valid = 1'b1;
        do
        begin
            rd_data = 8'h40 + 8'(n);
            rd_last = (n == 31);
            ok = rd_ready;
            tick(1);
            n += int'(ok);
        end
        while (ok === 1'b1 && n < 40);
        rd_valid = 1'b0;
        chk("fill", 8'(n), 8'(FIFO_D));
        chk("no talk", 8'(dio_oe), 8'h00);
        cmd(GRP_TAG | ADR);
        for (int i = 0; i < 32; i++)
        begin
            u_ctl.recv((i % 4 == 0) ? 6 : 0, b, e, ok);
            chk("talk byte", b, 8'h40 + 8'(i));
            chk("talk eoi", 8'(e), 8'(i == 31));
        end
        chk("talk ind", 8'(ind_talk), 8'h01);
        cmd(CMD_UNT);
        chk("drained", 8'(rd_ready), 8'h01);
    endtask

    task automatic t_talk_only;
        powerup(DIP & 8'hFE);
        chk("talk only", 8'(ind_talk), 8'h01);
        meas_cnt = 0;
        pulse(button_i);
        chk("button", 8'(meas_cnt), 8'h01);
        {rd_data, rd_last, rd_valid} = {8'h5A, 2'b11};
        tick(1);
        rd_valid = 1'b0;
        pulse(reading_done);
        chk("blink", 8'(ind_listen), 8'h01);
        u_ctl.recv(0, b, e, ok);
        chk("to byte", {b[6:0], e}, {7'h5A, 1'b1});
        chk("to ind", 8'(ind_talk), 8'h01);
    endtask

    task stop_test;
        begin
            $display("Checks %0d, errors %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    initial
    begin
        {err_count, check_count, cyc, rx_cnt, meas_cnt, clr_cnt} = '0;
        {button_i, reading_done, svc_req, rd_last, rd_valid} = '0;
        rd_data = 8'h00;
        rst_n = 1'b0;
        dip_sw = DIP;
        tick(1);
        powerup(DIP);
        t_reset;
        t_listen;
        t_poll;
        t_fifo;
        t_talk_only;
        stop_test;
    end
endmodule
